/* File: src/pcpl_map.vh */
// Constants shared by the control-pin qualification logic
`ifndef PCPL_MAP_VH
`define PCPL_MAP_VH

// ==========================================================
// Clock and timing
`define PCPL_LONG_PRESS_CYC 31'h47868c00
`define PCPL_QUAL_CYC       16'h2710

// ==========================================================
// Bit positions in the synchroniser bundle
`define PCPL_SY_W        15
`define PCPL_SY_PROC     0
`define PCPL_SY_PERIPH   1
`define PCPL_SY_KEY      2
`define PCPL_SY_PK1      3
`define PCPL_SY_PK2      4
`define PCPL_SY_PK3      5
`define PCPL_SY_CS       6
`define PCPL_SY_SDI      7
`define PCPL_SY_SCLK     8
`define PCPL_SY_SDA      9
`define PCPL_SY_IDLO     10
`define PCPL_SY_IDHI     11
`define PCPL_SY_TRIG     12
`define PCPL_SY_MDIG     13
`define PCPL_SY_MCORE    14
// Idle levels: keys and data line high, the rest low
`define PCPL_SY_RST      15'h023c

// ==========================================================
// Operating mode codes
`define PCPL_MODE_NORMAL 2'h0
`define PCPL_MODE_LPBOOT 2'h1
`define PCPL_MODE_TEST   2'h2

// ==========================================================
// Converter channels shared with the touch plates
`define PCPL_ADC_TS_BIT  2
`define PCPL_ROUTE_NONE  4'h0
`define PCPL_ROUTE_ONE   4'h1

`endif

/* File: src/pcpl_sync.v */
// Two-stage synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ps
module pcpl_sync #(
    parameter         W       = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input  wire         clk_in,
    input  wire         nrst_in,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge clk_in) begin
        if (!nrst_in) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

/* File: src/pcpl_long_press.v */
// Press and long-press detector for the third power key
`timescale 1ns/1ps
module pcpl_long_press #(
    parameter [30:0] LP_CYCLES = 31'h47868c00
) (
    input  wire clk_in,
    input  wire nrst_in,
    input  wire key_low_in,
    input  wire enable_in,
    output wire turn_on_out,
    output wire long_reset_out
);
    reg        prev_q;
    reg [30:0] cnt_q;
    reg        on_q;
    reg        long_q;

    always @(posedge clk_in) begin
        if (!nrst_in) begin
            prev_q <= 1'b0;
            cnt_q  <= 31'h0;
            on_q   <= 1'b0;
            long_q <= 1'b0;
        end else begin
            prev_q <= key_low_in;
            on_q   <= key_low_in & ~prev_q;
            long_q <= ~key_low_in & prev_q & enable_in
                      & (cnt_q == LP_CYCLES);
            if (!key_low_in)
                cnt_q <= 31'h0;
            else if (cnt_q != LP_CYCLES)
                cnt_q <= cnt_q + 31'h1;
        end
    end

    assign turn_on_out    = on_q;
    assign long_reset_out = long_q;
endmodule

/* File: src/pcpl_control_pin_logic.v */
// Control-pin qualification logic of the power management device
//
// Overview of operation
// - Sleep event only when both sleep request inputs are active together.
// - Each sleep request input has its own programmable polarity.
// - Sleep inputs are qualified stable for a finite time before use.
// - Sleep inputs act only in On mode; ignored during start-up and watchdog.
// - A pending unmasked interrupt drives the interrupt output high.
// - Each power key input pulled low gives a turn-on event like the key.
// - Long-press reset control bit resets to 0; meaning depends on variant.
// - Control bit may change any time and takes effect at once.
// - Key three low longer than 12 s then released triggers global reset.
// - Global reset: power down, charger off, registers default, power up.
// - Key three low under 12 s is an ordinary turn-on request.
// - Mode strap selects normal, low-power USB boot or test mode.
// - Chip select low at cold start latches SPI mode and acts as select.
// - Chip select high at cold start latches I2C mode, pin unused after.
// - In I2C mode the serial data input strap selects one of two addresses.
// - In I2C mode SPI clock is SCL and serial output is bidirectional SDA.
// - Sense bits report cable id floating, grounded or factory mode.
// - Regulator input-select bit at 1 connects cable supply to regulator.
// - Rising edge on conversion trigger starts an analog conversion.
// - Touch plates feed converter channels 4 to 7 while touch is inactive.
`timescale 1ns/1ps
`include "pcpl_map.vh"

module pcpl_control_pin_logic #(
    parameter        GR_PRESENT     = 1,
    parameter        GR_ACTIVE_HIGH = 0,
    parameter [30:0] LP_CYCLES      =
        `PCPL_LONG_PRESS_CYC,
    parameter [15:0] QUAL_CYCLES    =
        `PCPL_QUAL_CYC
) (
    input  wire       clk_in,
    input  wire       nrst_in,
    input  wire       proc_sleep_request_in,
    input  wire       peripheral_sleep_request_in,
    input  wire       proc_pol_high_in,
    input  wire       periph_pol_high_in,
    input  wire       on_mode_in,
    input  wire       irq_pending_in,
    input  wire       power_key_n_in,
    input  wire       power_key_input_one_n_in,
    input  wire       power_key_input_two_n_in,
    input  wire       power_key_input_three_n_in,
    input  wire       long_press_reset_ctrl_in,
    input  wire       seq_off_done_in,
    input  wire       cold_start_in,
    input  wire       mode_at_dig_core_in,
    input  wire       mode_at_core_in,
    input  wire       chip_select_in,
    input  wire       serial_data_in_in,
    input  wire       serial_clk_in,
    input  wire       sda_in,
    input  wire       sda_drive_low_in,
    input  wire       cable_id_below_low_in,
    input  wire       cable_id_above_high_in,
    input  wire       usb_reg_input_select_in,
    input  wire       conversion_trigger_in,
    input  wire       touch_active_in,
    input  wire [2:0] adc_channel_in,
    output wire       sleep_event_out,
    output wire       irq_out,
    output wire       turn_on_event_out,
    output wire       gr_power_down_out,
    output wire       gr_charger_off_out,
    output wire       gr_reg_restore_out,
    output wire       gr_power_up_out,
    output wire [1:0] op_mode_out,
    output wire       bus_mode_i2c_out,
    output wire       i2c_addr_sel_out,
    output wire       spi_select_out,
    output wire       i2c_scl_out,
    output wire       i2c_sda_in_out,
    output wire       sda_out,
    output wire       sda_oe_n_out,
    output wire       cable_id_floating_out,
    output wire       cable_id_grounded_out,
    output wire       cable_id_factory_out,
    output wire       cable_supply_connect_out,
    output wire       adc_start_out,
    output wire [3:0] touch_route_out
);
    // ==========================================================
    // Global reset sequence states
    localparam [3:0] GR_IDLE    = 4'h1;
    localparam [3:0] GR_DOWN    = 4'h2;
    localparam [3:0] GR_RESTORE = 4'h4;
    localparam [3:0] GR_UP      = 4'h8;

    // ==========================================================
    // Synchronised pins
    wire [`PCPL_SY_W-1:0] pins_raw;
    wire [`PCPL_SY_W-1:0] pins_s;

    assign pins_raw = {mode_at_core_in, mode_at_dig_core_in,
                       conversion_trigger_in, cable_id_above_high_in,
                       cable_id_below_low_in, sda_in, serial_clk_in,
                       serial_data_in_in, chip_select_in,
                       power_key_input_three_n_in,
                       power_key_input_two_n_in,
                       power_key_input_one_n_in, power_key_n_in,
                       peripheral_sleep_request_in,
                       proc_sleep_request_in};

    pcpl_sync #(
        .W       (`PCPL_SY_W),
        .RST_VAL (`PCPL_SY_RST)
    ) u_sync (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .async_in (pins_raw),
        .sync_out (pins_s)
    );

    // ==========================================================
    // Functions
    function active_level;
        input pin;
        input pol_high;
        begin
            active_level = pol_high ? pin : ~pin;
        end
    endfunction

    function [3:0] plate_route;
        input       active;
        input [2:0] chan;
        begin
            if (!active && chan[`PCPL_ADC_TS_BIT])
                plate_route = `PCPL_ROUTE_ONE << chan[1:0];
            else
                plate_route = `PCPL_ROUTE_NONE;
        end
    endfunction

    // ==========================================================
    // Sleep event decoding and qualification
    wire        sleep_raw;
    reg         sleep_qual_q;
    reg  [15:0] qual_cnt_q;
    reg         sleep_ev_q;

    assign sleep_raw =
        active_level(pins_s[`PCPL_SY_PROC], proc_pol_high_in)
        & active_level(pins_s[`PCPL_SY_PERIPH], periph_pol_high_in);

    always @(posedge clk_in) begin
        if (!nrst_in) begin
            sleep_qual_q <= 1'b0;
            qual_cnt_q   <= 16'h0;
            sleep_ev_q   <= 1'b0;
        end else begin
            if (sleep_raw == sleep_qual_q) begin
                qual_cnt_q <= 16'h0;
            end else if (qual_cnt_q >= QUAL_CYCLES - 16'h1) begin
                sleep_qual_q <= sleep_raw;
                qual_cnt_q   <= 16'h0;
            end else begin
                qual_cnt_q <= qual_cnt_q + 16'h1;
            end
            sleep_ev_q <= sleep_qual_q & on_mode_in;
        end
    end

    // ==========================================================
    // Power keys, long press and global reset sequence
    wire       pk3_on;
    wire       pk3_long;
    wire       gr_enable;
    wire [2:0] keys_low;
    reg  [2:0] keys_prev_q;
    reg        turn_on_q;
    reg  [3:0] gr_state_q;
    reg  [3:0] gr_state_d;
    reg        gr_down_q;
    reg        gr_chg_q;
    reg        gr_rest_q;
    reg        gr_up_q;

    assign keys_low = ~{pins_s[`PCPL_SY_PK2], pins_s[`PCPL_SY_PK1],
                        pins_s[`PCPL_SY_KEY]};
    assign gr_enable = (GR_PRESENT != 0) &
        (GR_ACTIVE_HIGH != 0 ? long_press_reset_ctrl_in
                             : ~long_press_reset_ctrl_in);

    pcpl_long_press #(
        .LP_CYCLES (LP_CYCLES)
    ) u_long_press (
        .clk_in         (clk_in),
        .nrst_in        (nrst_in),
        .key_low_in     (~pins_s[`PCPL_SY_PK3]),
        .enable_in      (gr_enable),
        .turn_on_out    (pk3_on),
        .long_reset_out (pk3_long)
    );

    always @* begin
        gr_state_d = gr_state_q;
        case (gr_state_q)
            GR_IDLE:    if (pk3_long) gr_state_d = GR_DOWN;
            GR_DOWN:    if (seq_off_done_in) gr_state_d = GR_RESTORE;
            GR_RESTORE: gr_state_d = GR_UP;
            GR_UP:      gr_state_d = GR_IDLE;
            default:    gr_state_d = GR_IDLE;
        endcase
    end

    always @(posedge clk_in) begin
        if (!nrst_in) begin
            keys_prev_q <= 3'h0;
            turn_on_q   <= 1'b0;
            gr_state_q  <= GR_IDLE;
            gr_down_q   <= 1'b0;
            gr_chg_q    <= 1'b0;
            gr_rest_q   <= 1'b0;
            gr_up_q     <= 1'b0;
        end else begin
            keys_prev_q <= keys_low;
            turn_on_q   <= (|(keys_low & ~keys_prev_q)) | pk3_on;
            gr_state_q  <= gr_state_d;
            gr_down_q   <= (gr_state_d == GR_DOWN);
            gr_chg_q    <= (gr_state_d != GR_IDLE);
            gr_rest_q   <= (gr_state_d == GR_RESTORE);
            gr_up_q     <= (gr_state_d == GR_UP);
        end
    end

    // ==========================================================
    // Straps latched at cold start and host bus pins
    reg [1:0] mode_q;
    reg       i2c_q;
    reg       addr_q;
    reg       spi_sel_q;
    reg       scl_q;
    reg       sda_in_q;
    reg       sda_oe_n_q;
    reg       sda_q;

    always @(posedge clk_in) begin
        if (!nrst_in) begin
            mode_q     <= `PCPL_MODE_NORMAL;
            i2c_q      <= 1'b0;
            addr_q     <= 1'b0;
            spi_sel_q  <= 1'b0;
            scl_q      <= 1'b0;
            sda_in_q   <= 1'b1;
            sda_oe_n_q <= 1'b1;
            sda_q      <= 1'b0;
        end else begin
            if (cold_start_in) begin
                if (pins_s[`PCPL_SY_MCORE])
                    mode_q <= `PCPL_MODE_TEST;
                else if (pins_s[`PCPL_SY_MDIG])
                    mode_q <= `PCPL_MODE_LPBOOT;
                else
                    mode_q <= `PCPL_MODE_NORMAL;
                i2c_q  <= pins_s[`PCPL_SY_CS];
                addr_q <= pins_s[`PCPL_SY_SDI];
            end
            spi_sel_q  <= ~i2c_q & pins_s[`PCPL_SY_CS];
            scl_q      <= i2c_q & pins_s[`PCPL_SY_SCLK];
            sda_in_q   <= ~i2c_q | pins_s[`PCPL_SY_SDA];
            sda_oe_n_q <= ~(i2c_q & sda_drive_low_in);
            sda_q      <= 1'b0;
        end
    end

    // ==========================================================
    // Interrupt, cable sense, converter trigger and routing
    reg       irq_q;
    reg       id_float_q;
    reg       id_gnd_q;
    reg       id_fact_q;
    reg       vbus_q;
    reg       trig_prev_q;
    reg       adc_start_q;
    reg [3:0] route_q;

    always @(posedge clk_in) begin
        if (!nrst_in) begin
            irq_q       <= 1'b0;
            id_float_q  <= 1'b0;
            id_gnd_q    <= 1'b0;
            id_fact_q   <= 1'b0;
            vbus_q      <= 1'b0;
            trig_prev_q <= 1'b0;
            adc_start_q <= 1'b0;
            route_q     <= `PCPL_ROUTE_NONE;
        end else begin
            irq_q       <= irq_pending_in;
            id_gnd_q    <= pins_s[`PCPL_SY_IDLO];
            id_fact_q   <= pins_s[`PCPL_SY_IDHI] & ~pins_s[`PCPL_SY_IDLO];
            id_float_q  <= ~pins_s[`PCPL_SY_IDHI] & ~pins_s[`PCPL_SY_IDLO];
            vbus_q      <= usb_reg_input_select_in;
            trig_prev_q <= pins_s[`PCPL_SY_TRIG];
            adc_start_q <= pins_s[`PCPL_SY_TRIG] & ~trig_prev_q;
            route_q     <= plate_route(touch_active_in, adc_channel_in);
        end
    end

    // ==========================================================
    // Outputs
    assign sleep_event_out          = sleep_ev_q;
    assign irq_out                  = irq_q;
    assign turn_on_event_out        = turn_on_q;
    assign gr_power_down_out        = gr_down_q;
    assign gr_charger_off_out       = gr_chg_q;
    assign gr_reg_restore_out       = gr_rest_q;
    assign gr_power_up_out          = gr_up_q;
    assign op_mode_out              = mode_q;
    assign bus_mode_i2c_out         = i2c_q;
    assign i2c_addr_sel_out         = addr_q;
    assign spi_select_out           = spi_sel_q;
    assign i2c_scl_out              = scl_q;
    assign i2c_sda_in_out           = sda_in_q;
    assign sda_out                  = sda_q;
    assign sda_oe_n_out             = sda_oe_n_q;
    assign cable_id_floating_out    = id_float_q;
    assign cable_id_grounded_out    = id_gnd_q;
    assign cable_id_factory_out     = id_fact_q;
    assign cable_supply_connect_out = vbus_q;
    assign adc_start_out            = adc_start_q;
    assign touch_route_out          = route_q;
endmodule

/* File: testbench/pcpl_far_side.sv */
// Far-side model: processor, peripheral, key driver and bus host on the pins
`timescale 1ns/1ps
module pcpl_far_side (
    input  wire proc_req_in,
    input  wire periph_req_in,
    input  wire proc_pol_in,
    input  wire periph_pol_in,
    input  wire press_three_in,
    input  wire cs_drive_in,
    output wire proc_pin_out,
    output wire periph_pin_out,
    output wire key_three_n_out,
    output wire cs_out
);
    // ==========================================================
    // Requests shown at each pin's own active level
    assign proc_pin_out    = proc_req_in ? proc_pol_in : ~proc_pol_in;
    assign periph_pin_out  = periph_req_in ? periph_pol_in : ~periph_pol_in;
    // Open-drain pull-down, pull-up when released
    assign key_three_n_out = press_three_in ? 1'b0 : 1'b1;
    // Host keeps select low through turn-on unless strapped high
    assign cs_out          = cs_drive_in;
endmodule

/* File: testbench/pcpl_control_pin_logic_monitor.sv */
// Concurrent checks on the control-pin logic ports
`timescale 1ns/1ps
module pcpl_control_pin_logic_monitor (
    input wire       clk_in,
    input wire       nrst_in,
    input wire       proc_sleep_request_in,
    input wire       peripheral_sleep_request_in,
    input wire       proc_pol_high_in,
    input wire       periph_pol_high_in,
    input wire       on_mode_in,
    input wire       irq_pending_in,
    input wire       power_key_input_one_n_in,
    input wire       power_key_input_three_n_in,
    input wire       long_press_reset_ctrl_in,
    input wire       conversion_trigger_in,
    input wire       touch_active_in,
    input wire [2:0] adc_channel_in,
    input wire       sleep_event_out,
    input wire       irq_out,
    input wire       turn_on_event_out,
    input wire       gr_power_down_out,
    input wire       gr_charger_off_out,
    input wire       gr_reg_restore_out,
    input wire       gr_power_up_out,
    input wire       adc_start_out,
    input wire [3:0] touch_route_out
);
    // ==========================================================
    // Helper terms
    wire       act = (proc_sleep_request_in == proc_pol_high_in) &&
                     (peripheral_sleep_request_in == periph_pol_high_in);
    wire       key_low = ~(power_key_input_one_n_in & power_key_input_three_n_in);
    wire [3:0] route_exp = (touch_active_in | ~adc_channel_in[2]) ? 4'h0 :
                           4'h1 << adc_channel_in[1:0];
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // ==========================================================
    // Assertions
    property p_irq;
        $past(nrst_in) |-> irq_out == $past(irq_pending_in);
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");
    property p_route;
        $past(nrst_in) |-> touch_route_out == $past(route_exp);
    endproperty
    a_route: assert property (p_route) else $error("route mismatch");
    property p_sleep_off;
        !on_mode_in |=> !sleep_event_out;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("sleep off On");
    property p_sleep_qual;
        $rose(sleep_event_out) |-> $past(act, 4) && $past(act, 5);
    endproperty
    a_sleep_qual: assert property (p_sleep_qual) else $error("sleep early");
    property p_turn;
        turn_on_event_out |-> $past(key_low, 2) ##1 !turn_on_event_out;
    endproperty
    a_turn: assert property (p_turn) else $error("turn-on bad");
    property p_gr_cause;
        $rose(gr_power_down_out) |->
            $past(power_key_input_three_n_in, 2) && !$past(long_press_reset_ctrl_in, 2);
    endproperty
    a_gr_cause: assert property (p_gr_cause) else $error("reset cause");
    property p_gr_seq;
        gr_reg_restore_out |-> $past(gr_power_down_out) && gr_charger_off_out
            ##1 gr_power_up_out ##1 !gr_charger_off_out;
    endproperty
    a_gr_seq: assert property (p_gr_seq) else $error("reset order");
    property p_adc;
        adc_start_out |-> $past(conversion_trigger_in, 2) ##1 !adc_start_out;
    endproperty
    a_adc: assert property (p_adc) else $error("adc start bad");
    c_sleep: cover property ($rose(sleep_event_out));
    c_gr: cover property (gr_power_up_out);
    c_adc: cover property (adc_start_out);
endmodule
bind pcpl_control_pin_logic pcpl_control_pin_logic_monitor pcpl_control_pin_logic_monitor_inst (.*);

/* File: testbench/pcpl_control_pin_logic_tb_top.sv */
// Self-checking bench for the control-pin logic
`timescale 1ns/1ps
module pcpl_control_pin_logic_tb_top;
    // ==========================================================
    // Signals
    logic clk_in, nrst_in, proc_pol_high_in, periph_pol_high_in, on_mode_in;
    logic irq_pending_in, power_key_input_one_n_in, long_press_reset_ctrl_in;
    logic seq_off_done_in, cold_start_in, mode_at_dig_core_in, mode_at_core_in;
    logic serial_data_in_in, serial_clk_in, sda_drive_low_in, touch_active_in;
    logic cable_id_below_low_in, cable_id_above_high_in, usb_reg_input_select_in;
    logic conversion_trigger_in, p_req, x_req, press3, cs_high;
    logic [2:0] adc_channel_in;
    logic power_key_n_in, power_key_input_two_n_in;
    wire  proc_sleep_request_in, peripheral_sleep_request_in;
    wire  power_key_input_three_n_in, chip_select_in;
    wire  sleep_event_out, irq_out, turn_on_event_out, gr_power_down_out;
    wire  gr_charger_off_out, gr_reg_restore_out, gr_power_up_out, bus_mode_i2c_out;
    wire  i2c_addr_sel_out, spi_select_out, i2c_scl_out, i2c_sda_in_out, sda_out;
    wire  sda_oe_n_out, cable_id_floating_out, cable_id_grounded_out;
    wire  sda_in = sda_oe_n_out | sda_out;
    wire  cable_id_factory_out, cable_supply_connect_out, adc_start_out;
    wire  [1:0] op_mode_out;
    wire  [3:0] touch_route_out;
    int   i, error_cnt, n_compared;
    // Rows: irq, supply select, touch active, channel, expected route
    logic [9:0] rows [7] = '{10'h241, 10'h152, 10'h364, 10'h078, 10'h230, 10'h1d0, 10'h000};

    pcpl_control_pin_logic #(.LP_CYCLES(31'h32), .QUAL_CYCLES(16'h4))
        pcpl_control_pin_logic_inst (.*);
    pcpl_far_side pcpl_far_side_inst (.proc_req_in(p_req), .periph_req_in(x_req),
        .proc_pol_in(proc_pol_high_in), .periph_pol_in(periph_pol_high_in),
        .press_three_in(press3), .cs_drive_in(cs_high),
        .proc_pin_out(proc_sleep_request_in), .periph_pin_out(peripheral_sleep_request_in),
        .key_three_n_out(power_key_input_three_n_in), .cs_out(chip_select_in));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // ==========================================================
    // Helpers
    task end_of_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    function logic pick(input int s);
        case (s)
            0: pick = sleep_event_out;
            1: pick = turn_on_event_out;
            2: pick = gr_power_down_out;
            3: pick = gr_power_up_out;
            default: pick = adc_start_out;
        endcase
    endfunction
    task wait_sig(input int s, input logic v, input int lim);
        int k;
        logic hit;
        hit = 1'b0;
        for (k = 0; k < lim && !hit; k++) begin
            @(posedge clk_in);
            #1;
            hit = (pick(s) === v);
        end
        chk(hit, "wait ran out");
        if (!hit) end_of_test();
    endtask
    task hold_off(input int s, input int n);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            @(posedge clk_in);
            #1;
            if (pick(s) !== 1'b0) bad = 1'b1;
        end
        chk(!bad, "unexpected output");
    endtask
    task press_three(input int n, input logic late_ctrl);
        @(posedge clk_in);
        press3 <= 1'b1;
        repeat (n) @(posedge clk_in);
        long_press_reset_ctrl_in <= late_ctrl;
        repeat (5) @(posedge clk_in);
        press3 <= 1'b0;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        {nrst_in, proc_pol_high_in, periph_pol_high_in, on_mode_in, irq_pending_in} = 5'h0;
        {long_press_reset_ctrl_in, seq_off_done_in, cold_start_in, mode_at_core_in} = 4'h0;
        {mode_at_dig_core_in, serial_data_in_in, serial_clk_in, sda_drive_low_in} = 4'h0;
        {cable_id_below_low_in, cable_id_above_high_in, usb_reg_input_select_in} = 3'h0;
        {conversion_trigger_in, touch_active_in, p_req, x_req, press3, cs_high} = 6'h0;
        adc_channel_in = 3'h0;
        {power_key_n_in, power_key_input_one_n_in, power_key_input_two_n_in} = 3'h7;
        error_cnt = 0;
        n_compared = 0;
        repeat (11) @(posedge clk_in);
        #1;
        chk({sleep_event_out, irq_out, gr_charger_off_out, op_mode_out, bus_mode_i2c_out,
             touch_route_out} === 10'h0 && sda_oe_n_out === 1'b1, "reset values");
        @(posedge clk_in);
        nrst_in <= 1'b1;
        on_mode_in <= 1'b1;
        for (i = 0; i < 7; i++) begin
            @(posedge clk_in);
            {irq_pending_in, usb_reg_input_select_in, touch_active_in, adc_channel_in} <=
                rows[i][9:4];
            @(posedge clk_in);
            #1;
            chk(irq_out === rows[i][9], "irq");
            chk(cable_supply_connect_out === rows[i][8], "supply");
            chk(touch_route_out === rows[i][3:0], "route");
        end
        $display("table test done");
        for (i = 0; i < 4; i++) begin
            @(posedge clk_in);
            {proc_pol_high_in, periph_pol_high_in} <= i[1:0];
            {p_req, x_req} <= 2'h3;
            wait_sig(0, 1'b1, 20);
            @(posedge clk_in);
            x_req <= 1'b0;
            wait_sig(0, 1'b0, 20);
        end
        hold_off(0, 15);
        @(posedge clk_in);
        x_req <= 1'b1;
        repeat (2) @(posedge clk_in);
        x_req <= 1'b0;
        hold_off(0, 15);
        @(posedge clk_in);
        on_mode_in <= 1'b0;
        x_req <= 1'b1;
        hold_off(0, 20);
        @(posedge clk_in);
        on_mode_in <= 1'b1;
        wait_sig(0, 1'b1, 20);
        @(posedge clk_in);
        {p_req, x_req} <= 2'h0;
        $display("sleep test done");
        @(posedge clk_in);
        power_key_input_one_n_in <= 1'b0;
        wait_sig(1, 1'b1, 8);
        hold_off(1, 10);
        for (i = 0; i < 2; i++) begin
            @(posedge clk_in);
            {power_key_n_in, power_key_input_two_n_in} <= i[0] ? 2'h2 : 2'h1;
            wait_sig(1, 1'b1, 8);
        end
        @(posedge clk_in);
        power_key_input_one_n_in <= 1'b1;
        power_key_input_two_n_in <= 1'b1;
        press3 <= 1'b1;
        wait_sig(1, 1'b1, 8);
        repeat (30) @(posedge clk_in);
        press3 <= 1'b0;
        hold_off(2, 20);
        press_three(65, 1'b0);
        wait_sig(2, 1'b1, 10);
        chk(gr_charger_off_out === 1'b1, "charger on");
        hold_off(3, 5);
        @(posedge clk_in);
        seq_off_done_in <= 1'b1;
        @(posedge clk_in);
        seq_off_done_in <= 1'b0;
        wait_sig(3, 1'b1, 6);
        repeat (2) @(posedge clk_in);
        #1;
        chk(gr_charger_off_out === 1'b0, "charger held");
        press_three(65, 1'b1);
        hold_off(2, 20);
        @(posedge clk_in);
        long_press_reset_ctrl_in <= 1'b0;
        $display("key test done");
        for (i = 2; i >= 0; i--) begin
            @(posedge clk_in);
            {mode_at_core_in, mode_at_dig_core_in} <= (i == 2) ? 2'h3 : i[1:0];
            {cs_high, serial_data_in_in} <= {2{i == 2}};
            {serial_clk_in, sda_drive_low_in} <= 2'h0;
            repeat (4) @(posedge clk_in);
            cold_start_in <= 1'b1;
            @(posedge clk_in);
            cold_start_in <= 1'b0;
            @(posedge clk_in);
            #1;
            chk(op_mode_out === i[1:0], "mode");
            chk(bus_mode_i2c_out === (i == 2), "bus mode");
            chk(i2c_addr_sel_out === (i == 2), "address");
            @(posedge clk_in);
            {serial_clk_in, sda_drive_low_in, cs_high} <= 3'h7;
            repeat (5) @(posedge clk_in);
            #1;
            chk(i2c_scl_out === (i == 2), "scl");
            chk(sda_oe_n_out === (i != 2) && sda_out === 1'b0, "sda");
            chk(spi_select_out === (i != 2), "select");
            chk(i2c_sda_in_out === (i != 2), "sda in");
        end
        $display("strap test done");
        @(posedge clk_in);
        conversion_trigger_in <= 1'b1;
        wait_sig(4, 1'b1, 8);
        hold_off(4, 10);
        @(posedge clk_in);
        conversion_trigger_in <= 1'b0;
        hold_off(4, 8);
        for (i = 0; i < 3; i++) begin
            @(posedge clk_in);
            {cable_id_below_low_in, cable_id_above_high_in} <= i[1:0];
            repeat (5) @(posedge clk_in);
            #1;
            chk({cable_id_floating_out, cable_id_factory_out, cable_id_grounded_out} ===
                (3'h4 >> i), "cable id");
        end
        $display("converter test done");
        end_of_test();
    end
endmodule
